//--- common/tsc_pkg.sv
// Shared constants for the tuning synthesiser control pair
package tsc_pkg;
  // Clock and timing
  localparam int CLK_HZ = 100_000_000;
  localparam int REF_HZ = 4_000_000;
  // Comparison frequency in units of 0.1 Hz (7.8125 kHz)
  localparam int FCOMP_DHZ = 78_125;
  localparam int REF_DIV = (REF_HZ * 10) / FCOMP_DHZ;
  localparam int REF_CW = $clog2(REF_DIV);
  localparam int SCL_HZ = 100_000;
  localparam logic [15:0] HALF_DEF = 16'(CLK_HZ / (2 * SCL_HZ));
  // Address byte layout
  localparam logic [4:0] ADDR_FIXED = 5'h18;
  localparam logic [1:0] ADDR_ALWAYS = 2'h1;
  // Byte bit positions, bit 7 is the MSB
  localparam int POS_KIND = 7;
  localparam int POS_CUR = 6;
  localparam int POS_TEST = 5;
  localparam int POS_PUMP_OFF = 4;
  localparam int POS_DRV_OFF = 0;
  localparam int POS_PORT_LO = 2;
  // Programmed state after reset or power loss
  localparam logic [14:0] RATIO_RST = 15'h0000;
  localparam logic [7:0] PUMP_RST = 8'h8e;
  localparam logic [7:0] PORT_RST = 8'h00;
  localparam logic POR_RST = 1'b1;
  // Synchronisers start at idle wire levels, so no false edge follows reset
  localparam logic [10:0] PIN_IDLE = 11'h003;
  localparam logic SDA_IDLE = 1'b1;
  // Lock detector
  localparam logic [7:0] LOCK_WIN = 8'h04;
  localparam logic [3:0] LOCK_CNT = 4'h8;
  // Controller registers
  localparam int REG_AW = 4;
  localparam int REG_DW = 32;
  localparam logic [3:0] OFF_CMD = 4'h0;
  localparam logic [3:0] OFF_STAT = 4'h4;
  localparam logic [3:0] OFF_RXD = 4'h8;
  localparam logic [3:0] OFF_HALF = 4'hc;
  localparam int CMD_OP_LO = 8;
  localparam int CMD_ACK = 10;
  localparam logic [1:0] OP_START = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_STOP = 2'h3;
endpackage : tsc_pkg

//--- common/tsc_if.sv
// Two-wire bus between the tuning controller and the synthesiser
`timescale 1ns/1ps
`default_nettype none
interface tsc_if;
  logic ctl_scl_oe;
  logic ctl_sda_oe;
  logic dev_sda_oe;
  logic scl;
  logic sda;
  // Open-drain: any enable pulls the wire low
  assign scl = ~ctl_scl_oe;
  assign sda = ~(ctl_sda_oe | dev_sda_oe);
  modport ctl (output ctl_scl_oe, output ctl_sda_oe, input scl, input sda);
  modport dev (output dev_sda_oe, input scl, input sda);
endinterface : tsc_if
`default_nettype wire

//--- hw/tsc_synth_ctrl.sv
// Synthesiser end: bus target, programmed state, divider and lock
// Functional notes
// - Address LSB high reads, low writes
// - Match fixed bits plus band or 01
// - Acknowledge address and every written byte
// - Controller acknowledges to get another status
// - First data bit picks ratio or pump
// - Ratio lead then low; pump then port
// - Bytes continue until stop without readdress
// - Stop mid-byte keeps previous value
// - Fifteen-bit ratio sets divider modulus
// - Frequency is ratio times eight times comparison
// - Comparison clock is reference over 512
// - Pump bit 2 selects high current
// - Pump bit 4 disables charge pump
// - Pump bit 8 switches drive off
// - Bit 3 routes test clocks to ports
// - Port byte top six bits drive ports
// - All bytes MSB first
// - Power-loss flag set, cleared by read stop
// - Ports high impedance after power-up
// - Status bit 2 shows lock
// - Status bits 3-5 show port levels
// - Status bits 6-8 carry level code
`timescale 1ns/1ps
`default_nettype none
module tsc_synth_ctrl (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic ce,
  tsc_if.dev bus,
  input wire logic [1:0] addr_band,
  input wire logic port_in_high,
  input wire logic port_in_mid,
  input wire logic port_in_low,
  input wire logic [2:0] level_code,
  input wire logic supply_low,
  input wire logic ref_tick,
  input wire logic presc_tick,
  output logic [14:0] divider_ratio,
  output logic pump_up,
  output logic pump_down,
  output logic pump_current_select,
  output logic drive_output_off,
  output logic [5:0] port_sink,
  output logic lock_flag
);
  import tsc_pkg::*;

  typedef enum logic [2:0] {
    D_IDLE, D_ADDR, D_WDATA, D_ACK, D_RDATA, D_RACK
  } tsc_dst_t;

  // Pin vector: supply, level code, in high/mid/low, band, sda, scl
  typedef struct packed {
    logic [10:0] s1;
    logic [10:0] s2;
    logic [10:0] s3;
    logic [10:0] f;
    tsc_dst_t st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic rd;
    logic rack;
    logic second;
    logic pend_port;
    logic [6:0] lead;
    logic [14:0] ratio;
    logic [7:0] pump;
    logic [7:0] port;
    logic por;
    logic sda_oe;
    logic [REF_CW-1:0] refc;
    logic [14:0] divc;
    logic up;
    logic dn;
    logic [7:0] err;
    logic [3:0] good;
  } tsc_dev_t;

  localparam tsc_dev_t DEV_RST = '{st: D_IDLE, ratio: RATIO_RST,
    pump: PUMP_RST, port: PORT_RST, por: POR_RST, s1: PIN_IDLE,
    s2: PIN_IDLE, s3: PIN_IDLE, f: PIN_IDLE, default: '0};

  tsc_dev_t q;
  tsc_dev_t n;
  logic [10:0] pins;
  logic [7:0] status;
  logic fcomp;
  logic fdiv;

  assign pins = {supply_low, level_code, port_in_high, port_in_mid,
                 port_in_low, addr_band, bus.sda, bus.scl};
  assign status = {q.por, lock_flag, q.f[6], q.f[5], q.f[4], q.f[9:7]};
  assign fcomp = q.refc < REF_CW'(REF_DIV / 2);
  assign fdiv = q.divc > (q.ratio >> 1);

  always_comb begin
    logic [10:0] nf;
    logic scl_r;
    logic scl_f;
    logic start_c;
    logic stop_c;
    logic comp_ev;
    logic div_ev;
    logic nu;
    logic nd;
    n = q;
    // Change counts once stages two and three agree
    nf = (q.s3 & ~(q.s2 ^ q.s3)) | (q.f & (q.s2 ^ q.s3));
    n.s1 = pins;
    n.s2 = q.s1;
    n.s3 = q.s2;
    n.f = nf;
    scl_r = ~q.f[0] & nf[0];
    scl_f = q.f[0] & ~nf[0];
    start_c = q.f[0] & nf[0] & q.f[1] & ~nf[1];
    stop_c = q.f[0] & nf[0] & ~q.f[1] & nf[1];

    if (start_c) begin
      n.st = D_ADDR;
      n.cnt = '0;
      n.sda_oe = 1'b0;
      n.second = 1'b0;
    end else if (stop_c) begin
      // Read ended by stop clears flag
      if (q.rd) begin
        n.por = 1'b0;
      end
      n.st = D_IDLE;
      n.rd = 1'b0;
      n.sda_oe = 1'b0;
    end else begin
      unique case (q.st)
        D_IDLE: begin
        end
        D_ADDR, D_WDATA: begin
          if (scl_r && q.cnt < 4'h8) begin
            n.sh = {q.sh[6:0], q.f[1]};
            n.cnt = q.cnt + 4'h1;
          end
          if (scl_f && q.cnt == 4'h8) begin
            n.cnt = '0;
            if (q.st == D_ADDR) begin
              // Fixed bits and band or always-valid
              if (q.sh[7:3] == ADDR_FIXED &&
                  (q.sh[2:1] == ADDR_ALWAYS || q.sh[2:1] == q.f[3:2])) begin
                n.st = D_ACK;
                n.sda_oe = 1'b1;
                n.rd = q.sh[0];
              end else begin
                n.st = D_IDLE;
              end
            end else begin
              if (!q.second) begin
                n.second = 1'b1;
                if (!q.sh[POS_KIND]) begin
                  n.lead = q.sh[6:0];
                  n.pend_port = 1'b0;
                end else begin
                  n.pump = q.sh;
                  n.pend_port = 1'b1;
                end
              end else begin
                n.second = 1'b0;
                if (q.pend_port) begin
                  n.port = q.sh;
                end else begin
                  n.ratio = {q.lead, q.sh};
                end
              end
              n.st = D_ACK;
              n.sda_oe = 1'b1;
            end
          end
        end
        D_ACK: begin
          if (scl_f) begin
            n.cnt = '0;
            if (q.rd) begin
              n.st = D_RDATA;
              n.sh = status;
              n.sda_oe = ~status[7];
            end else begin
              n.st = D_WDATA;
              n.sda_oe = 1'b0;
            end
          end
        end
        D_RDATA: begin
          if (scl_f) begin
            if (q.cnt == 4'h7) begin
              n.st = D_RACK;
              n.sda_oe = 1'b0;
            end else begin
              n.cnt = q.cnt + 4'h1;
              n.sh = {q.sh[6:0], 1'b0};
              n.sda_oe = ~q.sh[6];
            end
          end
        end
        D_RACK: begin
          // Low acknowledge asks for another byte
          if (scl_r) begin
            n.rack = ~q.f[1];
          end
          if (scl_f) begin
            n.cnt = '0;
            if (q.rack) begin
              n.st = D_RDATA;
              n.sh = status;
              n.sda_oe = ~status[7];
            end else begin
              n.st = D_IDLE;
            end
          end
        end
      endcase
    end

    // Supply loss wins over the clear
    if (q.f[10]) begin
      n.por = 1'b1;
      n.ratio = RATIO_RST;
      n.pump = PUMP_RST;
      n.port = PORT_RST;
    end

    comp_ev = 1'b0;
    if (ref_tick) begin
      if (q.refc == REF_CW'(REF_DIV - 1)) begin
        n.refc = '0;
        comp_ev = 1'b1;
      end else begin
        n.refc = q.refc + REF_CW'(1);
      end
    end

    div_ev = 1'b0;
    if (presc_tick) begin
      if (q.divc <= 15'h0001) begin
        n.divc = q.ratio;
        div_ev = 1'b1;
      end else begin
        n.divc = q.divc - 15'h0001;
      end
    end

    // Phase comparator; error measured in clock cycles
    nu = q.up | comp_ev;
    nd = q.dn | div_ev;
    if (nu && nd) begin
      if (q.err <= LOCK_WIN) begin
        n.good = (q.good == LOCK_CNT) ? q.good : q.good + 4'h1;
      end else begin
        n.good = '0;
      end
      n.err = '0;
      n.up = 1'b0;
      n.dn = 1'b0;
    end else begin
      n.up = nu;
      n.dn = nd;
      if ((nu || nd) && q.err != 8'hff) begin
        n.err = q.err + 8'h01;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      q <= DEV_RST;
    end else if (ce) begin
      q <= n;
    end
  end

  assign bus.dev_sda_oe = q.sda_oe;
  assign divider_ratio = q.ratio;
  assign lock_flag = q.good == LOCK_CNT;
  assign pump_up = q.up & ~q.dn & ~q.pump[POS_PUMP_OFF];
  assign pump_down = q.dn & ~q.up & ~q.pump[POS_PUMP_OFF];
  assign pump_current_select = q.pump[POS_CUR];
  assign drive_output_off = q.pump[POS_DRV_OFF];
  assign port_sink[3:0] = q.port[POS_PORT_LO+3:POS_PORT_LO];
  assign port_sink[4] = q.pump[POS_TEST] ? fcomp : q.port[6];
  assign port_sink[5] = q.pump[POS_TEST] ? fdiv : q.port[7];
endmodule : tsc_synth_ctrl
`default_nettype wire

//--- hw/tsc_bus_ctrl.sv
// Controller end: register-driven bus master for the synthesiser
`timescale 1ns/1ps
`default_nettype none
module tsc_bus_ctrl (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic ce,
  tsc_if.ctl bus,
  input wire logic [tsc_pkg::REG_AW-1:0] reg_addr,
  input wire logic [tsc_pkg::REG_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [tsc_pkg::REG_DW-1:0] reg_rdata
);
  import tsc_pkg::*;

  typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} tsc_hst_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic f;
    tsc_hst_t st;
    logic [1:0] ph;
    logic [3:0] bi;
    logic [15:0] tmr;
    logic [15:0] half;
    logic rdop;
    logic ackreq;
    logic [7:0] tx;
    logic [7:0] rx;
    logic nack;
    logic scl_oe;
    logic sda_oe;
    logic [REG_DW-1:0] rdata;
  } tsc_host_t;

  localparam tsc_host_t HOST_RST = '{st: H_IDLE, half: HALF_DEF,
    s1: SDA_IDLE, s2: SDA_IDLE, s3: SDA_IDLE, f: SDA_IDLE, default: '0};

  tsc_host_t q;
  tsc_host_t n;

  always_comb begin
    logic [1:0] op;
    n = q;
    n.s1 = bus.sda;
    n.s2 = q.s1;
    n.s3 = q.s2;
    n.f = (q.s2 == q.s3) ? q.s3 : q.f;
    op = reg_wdata[CMD_OP_LO+1:CMD_OP_LO];

    // Register writes; commands while busy are dropped
    if (reg_wr) begin
      if (reg_addr == OFF_HALF) begin
        n.half = (reg_wdata[15:0] == '0) ? 16'h0001 : reg_wdata[15:0];
      end else if (reg_addr == OFF_CMD && q.st == H_IDLE) begin
        n.tmr = q.half;
        n.ph = '0;
        n.bi = '0;
        n.tx = reg_wdata[7:0];
        n.rdop = (op == OP_READ);
        n.ackreq = reg_wdata[CMD_ACK];
        unique case (op)
          OP_START: n.st = H_START;
          OP_WRITE, OP_READ: n.st = H_BIT;
          OP_STOP: n.st = H_STOP;
        endcase
      end
    end

    // Read data stands in the following cycle only
    n.rdata = '0;
    if (reg_rd) begin
      unique case (reg_addr)
        OFF_CMD: n.rdata = '0;
        OFF_STAT: n.rdata = REG_DW'({q.nack, q.st != H_IDLE});
        OFF_RXD: n.rdata = REG_DW'(q.rx);
        OFF_HALF: n.rdata = REG_DW'(q.half);
        default: n.rdata = '0;
      endcase
    end

    // Each phase lasts half + 1 cycles; a bit takes three phases, clock high for one
    if (q.st != H_IDLE) begin
      if (q.tmr != '0) begin
        n.tmr = q.tmr - 16'h0001;
      end else begin
        n.tmr = q.half;
        n.ph = q.ph + 2'h1;
        unique case (q.st)
          H_IDLE: begin
          end
          H_START: begin
            // Works as repeated start when the clock is held low
            unique case (q.ph)
              2'h0: n.sda_oe = 1'b0;
              2'h1: n.scl_oe = 1'b0;
              2'h2: n.sda_oe = 1'b1;
              2'h3: begin
                n.scl_oe = 1'b1;
                n.st = H_BIT;
                n.ph = '0;
              end
            endcase
          end
          H_BIT: begin
            if (q.ph == 2'h0) begin
              // Data MSB first; ninth bit is the acknowledge
              if (q.bi < 4'h8) begin
                n.sda_oe = q.rdop ? 1'b0 : ~q.tx[7];
              end else begin
                n.sda_oe = q.rdop & q.ackreq;
              end
            end else if (q.ph == 2'h1) begin
              n.scl_oe = 1'b0;
            end else begin
              n.scl_oe = 1'b1;
              n.ph = '0;
              if (q.bi < 4'h8) begin
                n.rx = {q.rx[6:0], q.f};
                n.tx = {q.tx[6:0], 1'b0};
                n.bi = q.bi + 4'h1;
              end else begin
                if (!q.rdop) begin
                  n.nack = q.f;
                end
                n.st = H_IDLE;
              end
            end
          end
          H_STOP: begin
            if (q.ph == 2'h0) begin
              n.sda_oe = 1'b1;
            end else if (q.ph == 2'h1) begin
              n.scl_oe = 1'b0;
            end else begin
              n.sda_oe = 1'b0;
              n.st = H_IDLE;
              n.ph = '0;
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      q <= HOST_RST;
    end else if (ce) begin
      q <= n;
    end
  end

  assign bus.ctl_scl_oe = q.scl_oe;
  assign bus.ctl_sda_oe = q.sda_oe;
  assign reg_rdata = q.rdata;
endmodule : tsc_bus_ctrl
`default_nettype wire

//--- dv/tsc_link_asserts.sv
// Checker for the two-wire link between controller and synthesiser
`timescale 1ns/1ps
`default_nettype none
module tsc_link_asserts (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic ctl_scl_oe,
  input wire logic ctl_sda_oe,
  input wire logic dev_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  AST_DEV_RISE_LOW: assert property ($rose(dev_sda_oe) |-> !scl)
    else $error("device began driving data with clock high");
  AST_DEV_FALL_LOW: assert property ($fell(dev_sda_oe) |-> !scl)
    else $error("device released data with clock high");
  // Data must hold while the clock is high
  AST_DEV_HOLD_HIGH: assert property
    (scl && $past(scl) |-> $stable(dev_sda_oe))
    else $error("device data moved while clock high");
  // Stuck-low data would hang the bus
  AST_DEV_BOUNDED: assert property
    ($rose(dev_sda_oe) |-> ##[1:400] !dev_sda_oe)
    else $error("device held data low too long");
  AST_NO_CLASH: assert property
    (scl && $past(scl) |-> !(ctl_sda_oe && dev_sda_oe))
    else $error("both ends drive data while clock high");
  AST_SCL_HIGH_MIN: assert property ($rose(scl) |-> scl [*8])
    else $error("clock high phase too short");
  AST_SCL_LOW_MIN: assert property ($fell(scl) |-> !scl [*8])
    else $error("clock low phase too short");
  AST_START_FREE: assert property
    (scl && $past(scl) && $fell(sda) |-> !dev_sda_oe)
    else $error("device drove data at a start");
  AST_RESET_IDLE: assert property
    ($rose(rst_b) |-> !ctl_scl_oe && !ctl_sda_oe && !dev_sda_oe)
    else $error("bus not released after reset");
  cover property ($rose(dev_sda_oe));
  cover property (scl && $past(scl) && $fell(sda));
  cover property (scl && $past(scl) && $rose(sda));
endmodule : tsc_link_asserts
`default_nettype wire

//--- dv/i2c_tuning_synth_control_bench.sv
// Self-checking bench for the controller and synthesiser pair
`timescale 1ns/1ps
`default_nettype none
module i2c_tuning_synth_control_bench;
  import tsc_pkg::*;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic supply_low = 1'b0;
  logic presc_tick = 1'b0;
  logic ce = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata;
  logic [1:0] addr_band = 2'h3;
  logic [2:0] pin_lvl = 3'h0;
  logic [2:0] level_code = 3'h0;
  logic [14:0] divider_ratio;
  logic [5:0] port_sink;
  logic pump_up, pump_down, pump_current_select, drive_output_off;
  logic lock_flag;
  int errors = 0;
  int n_tests = 0;
  int cyc = 0;
  tsc_if bus_if ();
  tsc_bus_ctrl tsc_bus_ctrl_i (.mclk(mclk), .rst_b(rst_b), .ce(ce),
    .bus(bus_if), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  // Reference tick every cycle keeps comparison period short
  tsc_synth_ctrl tsc_synth_ctrl_i (.mclk(mclk), .rst_b(rst_b), .ce(ce),
    .bus(bus_if), .addr_band(addr_band), .port_in_high(pin_lvl[2]),
    .port_in_mid(pin_lvl[1]), .port_in_low(pin_lvl[0]),
    .level_code(level_code), .supply_low(supply_low), .ref_tick(1'b1),
    .presc_tick(presc_tick), .divider_ratio(divider_ratio),
    .pump_up(pump_up), .pump_down(pump_down),
    .pump_current_select(pump_current_select),
    .drive_output_off(drive_output_off), .port_sink(port_sink),
    .lock_flag(lock_flag));
  tsc_link_asserts tsc_link_asserts_i (.mclk(mclk), .rst_b(rst_b),
    .ctl_scl_oe(bus_if.ctl_scl_oe), .ctl_sda_oe(bus_if.ctl_sda_oe),
    .dev_sda_oe(bus_if.dev_sda_oe), .scl(bus_if.scl), .sda(bus_if.sda));
  always #5 mclk = ~mclk;
  always @(posedge mclk) begin
    presc_tick <= ($urandom_range(7) == 0);
    cyc <= cyc + 1;
    if (cyc == 50000) begin
      errors = errors + 1;
      summarize();
    end
  end
  task automatic summarize();
    if (errors == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : summarize
  task automatic check(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic reg_wr_t(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : reg_wr_t
  task automatic reg_rd_t(input logic [3:0] a, output logic [31:0] d);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : reg_rd_t
  task automatic cmd(input logic [1:0] op, input logic [7:0] b,
      input logic ack, output logic nack);
    logic [31:0] s;
    int n;
    reg_wr_t(OFF_CMD, {21'h0, ack, op, b});
    s = 32'h1;
    for (n = 0; n < 300 && s[0]; n++) reg_rd_t(OFF_STAT, s);
    check("idle", s[0], 1'b0);
    nack = s[1];
  endtask : cmd
  task automatic send(input logic [7:0] b, input logic st,
      input logic exp);
    logic nk;
    cmd(st ? OP_START : OP_WRITE, b, 1'b0, nk);
    check("ack", nk, exp);
  endtask : send
  initial begin
    logic nk;
    logic [31:0] s;
    logic [31:0] q;
    logic [7:0] pump_m, port_m;
    logic [14:0] ratio_m;
    int i, j, n;
    void'($urandom(32'h61ae));
    repeat (5) @(posedge mclk);
    rst_b <= 1'b1;
    reg_wr_t(OFF_HALF, 32'h8);
    check("ports", port_sink, 6'h00);
    check("ratio", divider_ratio, RATIO_RST);
    check("lock", lock_flag, 1'b0);
    for (i = 0; i < 8; i++) begin
      addr_band <= {i[2], 1'b0};
      send({ADDR_FIXED, i[1:0], 1'b0}, 1'b1,
        !(i[1:0] == ADDR_ALWAYS || i[1:0] == {i[2], 1'b0}));
      cmd(OP_STOP, 8'h0, 1'b0, nk);
    end
    // pairs in either order, one frame
    for (i = 0; i < 3; i++) begin
      pump_m = {1'b1, 1'($urandom), 1'b0, i[1], 3'h7,
        1'($urandom)};
      port_m = 8'($urandom);
      ratio_m = 15'($urandom);
      q = i[0] ? {pump_m, port_m, 1'b0, ratio_m}
        : {1'b0, ratio_m, pump_m, port_m};
      send({ADDR_FIXED, ADDR_ALWAYS, 1'b0}, 1'b1, 1'b0);
      for (j = 0; j < 4; j++) send(q[31-8*j -: 8], 1'b0, 1'b0);
      cmd(OP_STOP, 8'h0, 1'b0, nk);
      check("ratio", divider_ratio, ratio_m);
      check("current_select", pump_current_select, pump_m[POS_CUR]);
      check("drive_off", drive_output_off, pump_m[POS_DRV_OFF]);
      check("ports", port_sink, port_m[7:2]);
      if (pump_m[POS_PUMP_OFF])
        check("pump", pump_up | pump_down, 1'b0);
    end
    send({ADDR_FIXED, ADDR_ALWAYS, 1'b0}, 1'b1, 1'b0);
    send({1'b0, ~ratio_m[14:8]}, 1'b0, 1'b0);
    cmd(OP_STOP, 8'h0, 1'b0, nk);
    check("ratio", divider_ratio, ratio_m);
    send({ADDR_FIXED, ADDR_ALWAYS, 1'b0}, 1'b1, 1'b0);
    send(8'hae, 1'b0, 1'b0);
    send(8'h00, 1'b0, 1'b0);
    cmd(OP_STOP, 8'h0, 1'b0, nk);
    n = 0;
    repeat (1024) begin
      @(posedge mclk);
      n += port_sink[4];
    end
    check("fcomp", n, 32'd512);
    // Frozen state must not see a supply loss
    ce <= 1'b0;
    supply_low <= 1'b1;
    repeat (8) @(posedge mclk);
    supply_low <= 1'b0;
    repeat (8) @(posedge mclk);
    ce <= 1'b1;
    repeat (8) @(posedge mclk);
    check("frozen", divider_ratio, ratio_m);
    supply_low <= 1'b1;
    repeat (8) @(posedge mclk);
    supply_low <= 1'b0;
    pin_lvl <= 3'($urandom);
    level_code <= 3'($urandom_range(4));
    repeat (8) @(posedge mclk);
    check("ratio", divider_ratio, RATIO_RST);
    check("ports", port_sink, 6'h00);
    // Lock bit masked: its timing is analog-dependent
    for (i = 0; i < 2; i++) begin
      send({ADDR_FIXED, ADDR_ALWAYS, 1'b1}, 1'b1, 1'b0);
      for (j = 0; j < 2; j++) begin
        cmd(OP_READ, 8'h0, j == 0, nk);
        reg_rd_t(OFF_RXD, s);
        check("status", s[7:0] & 8'hbf,
          {i == 0, 1'b0, pin_lvl, level_code});
      end
      cmd(OP_STOP, 8'h0, 1'b0, nk);
    end
    summarize();
  end
endmodule : i2c_tuning_synth_control_bench
`default_nettype wire
